// *** verilog/aci_i2c_target.v ***
// Serial-bus command interface of the converter
`timescale 1ns/10ps
`include "aci_regs.vh"
module aci_i2c_target #(
   parameter [20:0] CYC_RATE0 = `RATE0_CYCLES,
   parameter [20:0] CYC_RATE1 = `RATE1_CYCLES,
   parameter [20:0] CYC_RATE2 = `RATE2_CYCLES,
   parameter [20:0] CYC_RATE3 = `RATE3_CYCLES
) (
   input  wire        clk,
   input  wire        rstn,
   input  wire        sclIn,
   output reg         sclOut,
   output reg         sclOe,
   input  wire        sdaIn,
   output reg         sdaOut,
   output reg         sdaOe,
   input  wire [1:0]  addrStrapLo,
   input  wire [1:0]  addrStrapHi,
   output reg         resultReadyNOut,
   output reg         resultReadyNOe,
   input  wire [23:0] convData,
   output reg  [2:0]  inputSelect,
   output reg         gainFour,
   output reg  [1:0]  rateSelect,
   output reg         conversionModeBit,
   output reg         refSelect,
   output reg         midShort,
   output reg         converting,
   output reg         sleeping,
   output reg         statusReady
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_AACK = 3'h2;
   localparam [2:0] ST_WR   = 3'h3;
   localparam [2:0] ST_WACK = 3'h4;
   localparam [2:0] ST_RD   = 3'h5;
   localparam [2:0] ST_RACK = 3'h6;

   wire        sclSync;
   wire        sdaSync;
   wire [3:0]  strapSync;
   reg         sclPrev;
   reg         sdaPrev;
   reg  [1:0]  strapWait;
   reg  [6:0]  ownAddr;
   reg  [2:0]  state;
   reg  [3:0]  bitCnt;
   reg  [7:0]  rxShift;
   reg  [23:0] txData;
   reg         expectData;
   reg         hostNack;
   reg  [7:0]  cfg;
   reg         cmdReset;
   reg         cmdStart;
   reg         cmdSleep;
   reg         cmdRead;
   reg  [20:0] convCount;
   reg  [20:0] convPeriod;
   reg  [23:0] result;
   wire        sclRise;
   wire        sclFall;
   wire        startCond;
   wire        stopCond;
   wire        convDone;
   wire        next_ready;

   // Bus pins pass two flops before any logic
   aci_sync2 #(
      .WIDTH (2),
      .INIT  (2'h3)
   ) u_bus_sync (
      .clk  (clk),
      .rstn (rstn),
      .din  ({sclIn, sdaIn}),
      .dout ({sclSync, sdaSync})
   );

   aci_sync2 #(
      .WIDTH (4),
      .INIT  (4'h0)
   ) u_strap_sync (
      .clk  (clk),
      .rstn (rstn),
      .din  ({addrStrapHi, addrStrapLo}),
      .dout (strapSync)
   );

   assign sclRise   = sclSync & ~sclPrev;
   assign sclFall   = ~sclSync & sclPrev;
   assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
   assign stopCond  = sclSync & sclPrev & ~sdaPrev & sdaSync;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         sclPrev <= sclSync;
         sdaPrev <= sdaSync;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strapWait <= 2'h0;
         ownAddr   <= 7'h00;
      end else if (strapWait != 2'h3) begin
         strapWait <= strapWait + 2'h1;
         ownAddr   <= {`ADDR_PREFIX, strapSync};
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclOut <= 1'b0;
         sclOe  <= 1'b0;
         sdaOut <= 1'b0;
      end else begin
         sclOut <= 1'b0;
         sclOe  <= 1'b0;
         sdaOut <= 1'b0;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state      <= ST_IDLE;
         bitCnt     <= 4'h0;
         rxShift    <= 8'h00;
         txData     <= {3{`IDLE_FILL}};
         expectData <= 1'b0;
         hostNack   <= 1'b0;
         sdaOe      <= 1'b0;
         cfg        <= `CFG_RESET;
         cmdReset   <= 1'b0;
         cmdStart   <= 1'b0;
         cmdSleep   <= 1'b0;
         cmdRead    <= 1'b0;
      end else begin
         cmdReset <= 1'b0;
         cmdStart <= 1'b0;
         cmdSleep <= 1'b0;
         cmdRead  <= 1'b0;
         if (startCond) begin
            state      <= ST_ADDR;
            bitCnt     <= 4'h0;
            expectData <= 1'b0;
            sdaOe      <= 1'b0;
         end else if (stopCond) begin
            state      <= ST_IDLE;
            expectData <= 1'b0;
            sdaOe      <= 1'b0;
         end else begin
            case (state)
               ST_ADDR, ST_WR: begin
                  if (sclRise) begin
                     rxShift <= {rxShift[6:0], sdaSync};
                     bitCnt  <= bitCnt + 4'h1;
                  end else if (sclFall && bitCnt == 4'h8) begin
                     bitCnt <= 4'h0;
                     if (state == ST_ADDR) begin
                        if (rxShift[7:1] == ownAddr) begin
                           sdaOe    <= 1'b1;
                           hostNack <= rxShift[0];
                           state    <= ST_AACK;
                        end else begin
                           state <= ST_IDLE;
                        end
                     end else begin
                        sdaOe <= 1'b1;
                        state <= ST_WACK;
                        if (expectData) begin
                           cfg        <= rxShift;
                           expectData <= 1'b0;
                        end else begin
                           case (rxShift)
                              `CMD_RESET: begin
                                 cfg      <= `CFG_RESET;
                                 txData   <= {3{`IDLE_FILL}};
                                 cmdReset <= 1'b1;
                              end
                              `CMD_START: cmdStart <= 1'b1;
                              `CMD_SLEEP: cmdSleep <= 1'b1;
                              `CMD_READ_DATA: begin
                                 txData  <= result;
                                 cmdRead <= 1'b1;
                              end
                              `CMD_READ_CFG: txData <= {cfg, {2{`IDLE_FILL}}};
                              `CMD_READ_STATUS: begin
                                 txData <= {statusReady, 7'h00, {2{`IDLE_FILL}}};
                              end
                              `CMD_WRITE_CFG: expectData <= 1'b1;
                              default: expectData <= 1'b0;
                           endcase
                        end
                     end
                  end
               end
               ST_AACK: begin
                  if (sclFall) begin
                     bitCnt <= 4'h0;
                     if (hostNack) begin
                        sdaOe <= ~txData[23];
                        state <= ST_RD;
                     end else begin
                        sdaOe <= 1'b0;
                        state <= ST_WR;
                     end
                  end
               end
               ST_WACK: begin
                  if (sclFall) begin
                     sdaOe <= 1'b0;
                     state <= ST_WR;
                  end
               end
               ST_RD: begin
                  if (sclFall) begin
                     if (bitCnt == 4'h7) begin
                        sdaOe  <= 1'b0;
                        txData <= {txData[15:0], `IDLE_FILL};
                        state  <= ST_RACK;
                     end else begin
                        bitCnt <= bitCnt + 4'h1;
                        sdaOe  <= ~txData[22 - bitCnt[2:0]];
                     end
                  end
               end
               ST_RACK: begin
                  if (sclRise) begin
                     hostNack <= sdaSync;
                  end else if (sclFall) begin
                     bitCnt <= 4'h0;
                     if (hostNack) begin
                        state <= ST_IDLE;
                     end else begin
                        sdaOe <= ~txData[23];
                        state <= ST_RD;
                     end
                  end
               end
               default: begin
                  sdaOe <= 1'b0;
               end
            endcase
         end
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         inputSelect       <= 3'h0;
         gainFour          <= 1'b0;
         rateSelect        <= 2'h0;
         conversionModeBit <= 1'b0;
         refSelect         <= 1'b0;
         midShort          <= 1'b0;
      end else begin
         inputSelect       <= cfg[`CFG_SEL_HI:`CFG_SEL_LO];
         gainFour          <= cfg[`CFG_GAIN];
         rateSelect        <= cfg[`CFG_RATE_HI:`CFG_RATE_LO];
         conversionModeBit <= cfg[`CFG_MODE];
         refSelect         <= cfg[`CFG_REF];
         midShort          <= (cfg[`CFG_SEL_HI:`CFG_SEL_LO] == `SEL_MID_SHORT);
      end
   end

   always @* begin
      case (cfg[`CFG_RATE_HI:`CFG_RATE_LO])
         2'h0:    convPeriod = CYC_RATE0;
         2'h1:    convPeriod = CYC_RATE1;
         2'h2:    convPeriod = CYC_RATE2;
         default: convPeriod = CYC_RATE3;
      endcase
   end

   assign convDone = converting & (convCount >= convPeriod - 21'h1)
                     & ~cmdReset & ~cmdSleep & ~cmdStart;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         converting <= 1'b0;
         sleeping   <= 1'b0;
         convCount  <= 21'h0;
         result     <= 24'h000000;
      end else begin
         if (cmdReset) begin
            converting <= 1'b0;
            sleeping   <= 1'b0;
            convCount  <= 21'h0;
            result     <= 24'h000000;
         end else if (cmdSleep) begin
            converting <= 1'b0;
            sleeping   <= 1'b1;
            convCount  <= 21'h0;
         end else if (cmdStart) begin
            converting <= 1'b1;
            sleeping   <= 1'b0;
            convCount  <= 21'h0;
         end else if (convDone) begin
            result     <= convData;
            converting <= cfg[`CFG_MODE];
            convCount  <= 21'h0;
         end else if (converting) begin
            convCount <= convCount + 21'h1;
         end
      end
   end

   // New result wins over a same-cycle read clear; a same-cycle reset command wins over it
   assign next_ready = convDone | (statusReady & ~cmdRead & ~cmdReset);

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         statusReady     <= 1'b0;
         resultReadyNOut <= 1'b0;
         resultReadyNOe  <= 1'b0;
      end else begin
         statusReady     <= next_ready;
         resultReadyNOut <= 1'b0;
         // Pin low while a result waits
         resultReadyNOe  <= next_ready;
      end
   end
endmodule // aci_i2c_target

// *** verilog/aci_regs.vh ***
// Constants for the converter command interface
// Summary of operation
// - Act as a serial-bus target for standard, fast and fast-plus controllers.
// - Never pull the serial clock line low; no clock stretching.
// - Pick the 7-bit address from 16 values set by two strap pins.
// - Result-ready pin is open drain: only driven low, pulled high outside.
// - Drive result-ready low when a new result exists; controller waits for fall.
// - Command 06h resets the interface and converter state.
// - Command 40h plus one data byte loads the configuration register.
// - Command 20h returns the configuration register on the next read.
// - Command 08h starts converting; continuous mode keeps converting.
// - Command 10h returns the latest result as three bytes on next read.
// - Command 02h stops converting and enters power-down.
// - Input select 111 shorts both converter inputs to mid-supply.
// - Config: select 7:5, gain 4, rate 3:2, mode 1, reference 0; reset zero.
// - Status bit 7 sets on new result and clears when command 10h is received.
// - Rate codes 00,01,10,11 give 20, 90, 330 and 1000 samples per second.
`ifndef ACI_REGS_VH
`define ACI_REGS_VH

`define CLK_HZ          25000000
`define POWERUP_US      500
`define ADDR_PREFIX     3'h4
`define CMD_RESET       8'h06
`define CMD_START       8'h08
`define CMD_SLEEP       8'h02
`define CMD_READ_DATA   8'h10
`define CMD_READ_CFG    8'h20
`define CMD_READ_STATUS 8'h24
`define CMD_WRITE_CFG   8'h40
`define CFG_RESET       8'h00
`define CFG_SEL_HI      7
`define CFG_SEL_LO      5
`define CFG_GAIN        4
`define CFG_RATE_HI     3
`define CFG_RATE_LO     2
`define CFG_MODE        1
`define CFG_REF         0
`define STATUS_READY    7
`define SEL_MID_SHORT   3'h7
`define RATE0_SPS       20
`define RATE1_SPS       90
`define RATE2_SPS       330
`define RATE3_SPS       1000
// Clock cycles per result at each rate, clock rate over samples per second
`define RATE0_CYCLES    21'h1312D0
`define RATE1_CYCLES    21'h043D11
`define RATE2_CYCLES    21'h0127ED
`define RATE3_CYCLES    21'h0061A8
`define IDLE_FILL       8'hFF

`endif

// *** verilog/aci_sync2.v ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module aci_sync2 #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input  wire             clk,
   input  wire             rstn,
   input  wire [WIDTH-1:0] din,
   output reg  [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] stage;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage <= INIT;
         dout  <= INIT;
      end else begin
         stage <= din;
         dout  <= stage;
      end
   end
endmodule // aci_sync2

// *** dv/aci_i2c_target_monitor.sv ***
// Assertion checker for the converter command interface
`timescale 1ns/10ps
module aci_i2c_target_monitor (
   input wire       clk,
   input wire       rstn,
   input wire       sclIn,
   input wire       sclOe,
   input wire       sdaOut,
   input wire       sdaOe,
   input wire       resultReadyNOut,
   input wire       resultReadyNOe,
   input wire [2:0] inputSelect,
   input wire       gainFour,
   input wire       midShort,
   input wire       converting,
   input wire       sleeping,
   input wire       statusReady
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rstn);
   a_scl_never_driven: assert property (!sclOe)
      else $error("clock line driven");
   a_sda_low_only: assert property (sdaOe |-> !sdaOut)
      else $error("data line driven high");
   a_sda_while_low: assert property ($changed(sdaOe) |-> !sclIn)
      else $error("data changed with clock high");
   a_ready_open_drain: assert property (resultReadyNOe |-> !resultReadyNOut)
      else $error("ready pin driven high");
   a_pin_follows_flag: assert property (resultReadyNOe == statusReady)
      else $error("ready pin and flag differ");
   a_flag_from_conv: assert property ($rose(statusReady) |-> $past(converting))
      else $error("flag set without conversion");
   a_sleep_stopped: assert property (sleeping |-> !converting)
      else $error("converting while asleep");
   a_short_tracks_sel: assert property ($stable(inputSelect) |-> midShort == (inputSelect == 3'h7))
      else $error("short flag wrong");
   a_cfg_reset_zero: assert property ($rose(rstn) |-> inputSelect == 3'h0 && !gainFour)
      else $error("config not zero after reset");
   cover property ($rose(resultReadyNOe));
   cover property ($rose(sleeping));
   cover property ($rose(midShort));
endmodule // aci_i2c_target_monitor

bind aci_i2c_target aci_i2c_target_monitor mon (.clk(clk), .rstn(rstn), .sclIn(sclIn),
   .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .resultReadyNOut(resultReadyNOut),
   .resultReadyNOe(resultReadyNOe), .inputSelect(inputSelect), .gainFour(gainFour),
   .midShort(midShort), .converting(converting), .sleeping(sleeping),
   .statusReady(statusReady));

// *** dv/aci_host_model.sv ***
// Serial-bus controller model driving clock and data lines
`timescale 1ns/10ps
module aci_host_model (
   input  wire  clk,
   input  wire  sclIn,
   input  wire  sdaIn,
   output logic sclOe,
   output logic sdaOe
);
   initial begin
      sclOe = 1'b0;
      sdaOe = 1'b0;
   end
   task tick(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task bitx(input b, output r);
      sdaOe = !b;
      tick(4);
      sclOe = 1'b0;
      tick(8);
      r = sdaIn;
      sclOe = 1'b1;
      tick(4);
   endtask
   task start;
      sdaOe = 1'b1;
      tick(8);
      sclOe = 1'b1;
      tick(4);
   endtask
   task stop;
      sdaOe = 1'b1;
      tick(4);
      sclOe = 1'b0;
      tick(8);
      sdaOe = 1'b0;
      tick(8);
   endtask
   task sendByte(input [7:0] d, output ack);
      logic r;
      integer i;
      for (i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask
   task getByte(output [7:0] d, input last);
      logic r;
      integer i;
      for (i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(last, r);
   endtask
endmodule // aci_host_model

// *** dv/adc_i2c_command_interface_bench.sv ***
// Testbench for the converter command interface
`timescale 1ns/10ps
module adc_i2c_command_interface_bench;
   logic [1:0]  strapLo;
   logic [1:0]  strapHi;
   wire  [6:0]  devAddr = {3'h4, strapHi, strapLo};
   logic        clk;
   logic        rstn;
   logic [23:0] convData;
   logic        ack;
   logic [7:0]  rb [0:2];
   wire         sclOut, sclOe, sdaOut, sdaOe, rrOut, rrOe, gainFour, cmBit, refSelect;
   wire         midShort, converting, sleeping, statusReady, hSclOe, hSdaOe;
   wire [2:0]   inputSelect;
   wire [1:0]   rateSelect;
   wire         scl = ~(hSclOe | sclOe);
   wire         sda = ~(hSdaOe | sdaOe);
   wire         readyN = ~rrOe;
   wire [7:0]   cfg = {inputSelect, gainFour, rateSelect, cmBit, refSelect};
   integer      num_errors = 0;
   integer      total_checks = 0;
   integer      cycles = 0;

   aci_i2c_target #(.CYC_RATE0(21'd40), .CYC_RATE1(21'd30), .CYC_RATE2(21'd20),
      .CYC_RATE3(21'd10)) dut (.clk(clk), .rstn(rstn), .sclIn(scl), .sclOut(sclOut),
      .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrapLo(strapLo),
      .addrStrapHi(strapHi), .resultReadyNOut(rrOut), .resultReadyNOe(rrOe),
      .convData(convData), .inputSelect(inputSelect), .gainFour(gainFour),
      .rateSelect(rateSelect), .conversionModeBit(cmBit), .refSelect(refSelect),
      .midShort(midShort), .converting(converting), .sleeping(sleeping),
      .statusReady(statusReady));
   aci_host_model host (.clk(clk), .sclIn(scl), .sdaIn(sda), .sclOe(hSclOe), .sdaOe(hSdaOe));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task chk(input [31:0] seen, input [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         end_sim;
      end
   end
   task addr(input rd);
      host.start;
      host.sendByte({devAddr, rd}, ack);
      chk(ack, 1);
   endtask
   task cmdw(input [7:0] c);
      addr(1'b0);
      host.sendByte(c, ack);
      host.stop;
   endtask
   task cfgw(input [7:0] d);
      addr(1'b0);
      host.sendByte(8'h40, ack);
      host.sendByte(d, ack);
      host.stop;
   endtask
   task rdq(input [7:0] c, input integer n);
      integer i;
      cmdw(c);
      addr(1'b1);
      for (i = 0; i < n; i++) host.getByte(rb[i], i == n - 1);
      host.stop;
   endtask
   task waitReady;
      integer k;
      for (k = 0; k < 400 && readyN !== 1'b0; k++) begin
         @(posedge clk);
         #1;
      end
      chk(readyN, 0);
   endtask

   initial begin
      rstn = 1'b0;
      convData = 24'hA5C31E;
      strapLo = 2'h1;
      strapHi = 2'h2;
      repeat (10) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (12500) @(posedge clk);
      #1;
      chk(cfg, 8'h00);
      chk(readyN, 1);
      chk({sclOut, sclOe}, 2'h0);
      host.start;
      host.sendByte({devAddr ^ 7'h01, 1'b0}, ack);
      host.stop;
      chk(ack, 0);
      cmdw(8'h06);
      cfgw(8'h12);
      chk(cfg, 8'h12);
      rdq(8'h20, 1);
      chk(rb[0], 8'h12);
      cfgw(8'hEC);
      chk(midShort, 1);
      chk(rateSelect, 2'h3);
      cmdw(8'h08);
      waitReady;
      chk(statusReady, 1);
      rdq(8'h24, 1);
      chk(rb[0], 8'h80);
      rdq(8'h10, 3);
      chk({rb[0], rb[1], rb[2]}, 24'hA5C31E);
      chk({readyN, statusReady, converting}, 3'b100);
      cfgw(8'h12);
      cmdw(8'h08);
      chk(converting, 1);
      waitReady;
      rdq(8'h10, 3);
      waitReady;
      chk(converting, 1);
      cmdw(8'h02);
      chk({sleeping, converting}, 2'b10);
      cmdw(8'h06);
      chk({cfg, sleeping}, 9'h000);
      // New straps taken after a second reset
      rstn = 1'b0;
      strapHi = 2'h3;
      strapLo = 2'h0;
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      addr(1'b0);
      host.stop;
      chk({sclOut, sclOe, cfg}, 10'h000);
      end_sim;
   end
endmodule // adc_i2c_command_interface_bench
